// >>> include/iss_pkg.sv
// Constants and carrier types for the interrupt state save unit
package iss_pkg;

	// Special-purpose register numbers
	localparam logic [9:0]  SPR_NC_RET_ADDR  = 10'h01A;
	localparam logic [9:0]  SPR_NC_SAVED     = 10'h01B;
	localparam logic [9:0]  SPR_SYNDROME     = 10'h3D4;
	localparam logic [9:0]  SPR_PREFIX       = 10'h3D6;
	localparam logic [9:0]  SPR_CR_RET_ADDR  = 10'h3DE;
	localparam logic [9:0]  SPR_CR_SAVED     = 10'h3DF;

	// Reset values
	localparam logic [31:0] RST_RET_ADDR     = 32'h0000_0000;
	localparam logic [31:0] RST_SAVED        = 32'h0000_0000;
	localparam logic [31:0] RST_SYNDROME     = 32'h0000_0000;
	localparam logic [31:0] RST_PREFIX       = 32'h0000_0000;
	localparam logic [31:0] RST_READ         = 32'h0000_0000;

	// Field positions as LSB indices; bit n of the register is [31-n]
	localparam int          POS_MCHK_EN      = 12;
	localparam int          POS_INSTR_MCHK   = 31;
	localparam int          POS_ILLEGAL      = 27;
	localparam int          POS_PRIVILEGED   = 26;
	localparam int          POS_TRAP         = 25;
	localparam int          POS_UNIMPL       = 24;
	localparam int          POS_STORE        = 23;
	localparam int          POS_ZONE         = 22;
	localparam int          POS_FLOAT        = 19;
	localparam int          POS_AUX_PROC     = 18;
	localparam int          POS_USER_ATTR    = 15;

	// Writable syndrome bits: the defined and supported ones only
	localparam logic [31:0] SYN_WRITE_MASK   = 32'h8EC0_8000;
	localparam logic [31:0] SYN_UNSUP_MASK   = 32'h010C_0000;
	localparam logic [31:0] PREFIX_MASK      = 32'hFFFF_0000;
	localparam logic [1:0]  WORD_ALIGN_ZERO  = 2'h0;

	typedef enum logic [2:0] {
		IK_NONCRIT     = 3'h0,
		IK_SYSCALL     = 3'h1,
		IK_CRIT_INPUT  = 3'h3,
		IK_MCHECK      = 3'h2,
		IK_WATCHDOG    = 3'h6,
		IK_DEBUG       = 3'h7
	} iss_kind_t;

	typedef struct packed {
		logic illegal;
		logic privileged;
		logic trap;
		logic store;
		logic zone;
		logic fetch_noexec;
		logic user_attr;
		logic instr_mchk;
	} iss_cause_t;

	typedef struct packed {
		logic        take;
		iss_kind_t   kind;
		logic        next_seq;
		logic [31:0] cur_addr;
		logic [31:0] next_addr;
		logic [15:0] offset;
		logic        reports;
		iss_cause_t  cause;
	} iss_exc_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [9:0]  num;
		logic [31:0] wdata;
	} iss_spr_t;

endpackage

// >>> core/iss_core.sv
// Interrupt state save, vector formation and exception syndrome unit
// Functional notes
// RULE1 - Noncritical interrupt saves interrupted address, low two bits zero.
// RULE2 - Noncritical interrupt copies machine state into its saved state.
// RULE3 - Noncritical return redirects to noncritical return address.
// RULE4 - Noncritical return restores machine state from its saved state.
// RULE5 - Saved address is faulting or next; system call saves the next.
// RULE6 - Critical input, machine check, watchdog and debug use critical pair.
// RULE7 - Critical interrupt saves interrupted address, low two bits zero.
// RULE8 - Watchdog interrupt saves the next sequential address.
// RULE9 - Critical interrupt copies machine state into critical saved state.
// RULE10 - Critical return redirects and restores state from critical pair.
// RULE11 - Noncritical pair are special registers 26 and 27, read/write.
// RULE12 - Critical pair are special registers 990 and 991, read/write.
// RULE13 - Handler address is prefix upper half above 16-bit offset.
// RULE14 - Prefix register is special register 982, read/write.
// RULE15 - Syndrome flags illegal, privileged and trap at bits 4, 5, 6.
// RULE16 - Syndrome bit 8 flags store-type data storage or TLB miss.
// RULE17 - Syndrome bit 9 flags zone violation, zero for non-exec fetch.
// RULE18 - Syndrome bit 16 flags user attribute protection violation.
// RULE19 - Unimplemented, float and auxiliary syndrome bits never set.
// RULE20 - A reporting exception sets its bit and clears all others.
// RULE21 - With checks disabled, instruction machine-check bit stays set.
// RULE22 - With checks enabled, machine check sets bit 0 only.
// RULE23 - Syndrome register is special register 980, read/write.
// RULE24 - Machine-check enable is machine-state bit 19.
`timescale 1ns/1ps
module iss_core
	import iss_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire iss_pkg::iss_exc_t exc,
	input  wire logic [31:0]    msr_in,
	input  wire logic           rfi,
	input  wire logic           rfci,
	input  wire iss_pkg::iss_spr_t special_purpose_register,
	output logic [31:0]         spr_rdata,
	output logic                spr_ack,
	output logic                vector_valid,
	output logic [31:0]         vector_addr,
	output logic                redirect_valid,
	output logic [31:0]         redirect_addr,
	output logic [31:0]         msr_restore
);
	import iss_pkg::*;

	logic [31:0] nc_ret_addr;
	logic [31:0] nc_saved;
	logic [31:0] cr_ret_addr;
	logic [31:0] cr_saved;
	logic [31:0] syndrome;
	logic [31:0] prefix;

	wire         is_crit;
	wire         use_next;
	wire [31:0]  raw_addr;
	wire [31:0]  save_addr;
	wire         take_nc;
	wire         take_cr;
	wire         mchk_en;
	wire         syn_upd;
	wire [31:0]  syn_event;
	wire [31:0]  syn_other;
	wire [31:0]  next_syndrome;
	wire [31:0]  syn_wr_val;
	wire         wr_nc_addr;
	wire         wr_nc_saved;
	wire         wr_cr_addr;
	wire         wr_cr_saved;
	wire         wr_syn;
	wire         wr_prefix;
	logic [31:0] next_rdata;

	// RULE6 critical class select
	assign is_crit  = exc.kind == IK_CRIT_INPUT || exc.kind == IK_MCHECK ||
			  exc.kind == IK_WATCHDOG || exc.kind == IK_DEBUG;
	assign take_nc  = exc.take && !is_crit;
	assign take_cr  = exc.take && is_crit;

	// RULE5 RULE8 next address selection
	assign use_next = exc.next_seq || exc.kind == IK_SYSCALL ||
			  exc.kind == IK_WATCHDOG;
	assign raw_addr = use_next ? exc.next_addr : exc.cur_addr;
	// RULE1 RULE7 word alignment
	assign save_addr = {raw_addr[31:2], WORD_ALIGN_ZERO};

	// RULE24 enable bit of machine state
	assign mchk_en  = msr_in[POS_MCHK_EN];

	assign wr_nc_addr  = special_purpose_register.wr && special_purpose_register.num == SPR_NC_RET_ADDR;
	assign wr_nc_saved = special_purpose_register.wr && special_purpose_register.num == SPR_NC_SAVED;
	assign wr_cr_addr  = special_purpose_register.wr && special_purpose_register.num == SPR_CR_RET_ADDR;
	assign wr_cr_saved = special_purpose_register.wr && special_purpose_register.num == SPR_CR_SAVED;
	assign wr_syn      = special_purpose_register.wr && special_purpose_register.num == SPR_SYNDROME;
	assign wr_prefix   = special_purpose_register.wr && special_purpose_register.num == SPR_PREFIX;

	// RULE15 RULE16 RULE17 RULE18 RULE19 cause flags into syndrome
	assign syn_other = (32'h0000_0001 << POS_USER_ATTR) &
			   {32{exc.cause.user_attr}} |
			   (32'h0000_0001 << POS_ILLEGAL) &
			   {32{exc.cause.illegal}} |
			   (32'h0000_0001 << POS_PRIVILEGED) &
			   {32{exc.cause.privileged}} |
			   (32'h0000_0001 << POS_TRAP) &
			   {32{exc.cause.trap}} |
			   (32'h0000_0001 << POS_STORE) &
			   {32{exc.cause.store}} |
			   (32'h0000_0001 << POS_ZONE) &
			   {32{exc.cause.zone && !exc.cause.fetch_noexec}};

	// RULE20 RULE21 RULE22 syndrome replaced by cause flags, or by bit 0 alone on enabled machine check, with machine-check retention
	assign syn_event = exc.cause.instr_mchk && mchk_en ?
			   (32'h0000_0001 << POS_INSTR_MCHK) :
			   syn_other |
			   ((32'h0000_0001 << POS_INSTR_MCHK) &
			    {32{exc.cause.instr_mchk ||
				(!mchk_en && syndrome[POS_INSTR_MCHK])}});
	assign syn_upd    = exc.take && exc.reports;
	assign syn_wr_val = special_purpose_register.wdata & SYN_WRITE_MASK;
	// Hardware update wins over a software write in the same cycle
	assign next_syndrome = syn_upd ? syn_event :
			       wr_syn ? syn_wr_val : syndrome;

	// RULE11 RULE12 RULE14 RULE23 special register read decode
	always_comb begin
		case (special_purpose_register.num)
		SPR_NC_RET_ADDR: next_rdata = nc_ret_addr;
		SPR_NC_SAVED:    next_rdata = nc_saved;
		SPR_CR_RET_ADDR: next_rdata = cr_ret_addr;
		SPR_CR_SAVED:    next_rdata = cr_saved;
		SPR_SYNDROME:    next_rdata = syndrome;
		SPR_PREFIX:      next_rdata = prefix;
		default:         next_rdata = RST_READ;
		endcase
	end

	// RULE1 RULE2 RULE11 noncritical pair
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nc_ret_addr <= RST_RET_ADDR;
			nc_saved    <= RST_SAVED;
		end else if (take_nc) begin
			nc_ret_addr <= save_addr;
			nc_saved    <= msr_in;
		end else begin
			if (wr_nc_addr)
				nc_ret_addr <= special_purpose_register.wdata;
			if (wr_nc_saved)
				nc_saved <= special_purpose_register.wdata;
		end
	end

	// RULE7 RULE9 RULE12 critical pair
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cr_ret_addr <= RST_RET_ADDR;
			cr_saved    <= RST_SAVED;
		end else if (take_cr) begin
			cr_ret_addr <= save_addr;
			cr_saved    <= msr_in;
		end else begin
			if (wr_cr_addr)
				cr_ret_addr <= special_purpose_register.wdata;
			if (wr_cr_saved)
				cr_saved <= special_purpose_register.wdata;
		end
	end

	// RULE14 RULE23 prefix and syndrome storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prefix   <= RST_PREFIX;
			syndrome <= RST_SYNDROME;
		end else begin
			syndrome <= next_syndrome;
			if (wr_prefix)
				prefix <= special_purpose_register.wdata & PREFIX_MASK;
		end
	end

	// RULE13 handler address formation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vector_valid <= 1'b0;
			vector_addr  <= RST_RET_ADDR;
		end else begin
			vector_valid <= exc.take;
			if (exc.take)
				vector_addr <= {prefix[31:16], exc.offset};
		end
	end

	// RULE3 RULE4 RULE10 return redirect and state restore
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			redirect_valid <= 1'b0;
			redirect_addr  <= RST_RET_ADDR;
			msr_restore    <= RST_SAVED;
		end else begin
			redirect_valid <= rfi || rfci;
			if (rfci) begin
				redirect_addr <= cr_ret_addr;
				msr_restore   <= cr_saved;
			end else if (rfi) begin
				redirect_addr <= nc_ret_addr;
				msr_restore   <= nc_saved;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spr_ack   <= 1'b0;
			spr_rdata <= RST_READ;
		end else begin
			spr_ack <= special_purpose_register.rd || special_purpose_register.wr;
			if (special_purpose_register.rd)
				spr_rdata <= next_rdata;
		end
	end

	nc_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		take_nc |=> nc_ret_addr == $past(save_addr) &&
			nc_ret_addr[1:0] == 2'h0)
		else $error("noncritical return address not saved");

	nc_state_a: assert property (@(posedge clk) disable iff (rst) // RULE2
		take_nc |=> nc_saved == $past(msr_in) &&
			($stable(cr_saved) || $past(wr_cr_saved)))
		else $error("noncritical saved state not copied");

	sc_next_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		exc.take && exc.kind == IK_SYSCALL |=>
			nc_ret_addr[31:2] == $past(exc.next_addr[31:2]))
		else $error("system call did not save next address");

	crit_pair_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		take_cr |=> ($stable(nc_ret_addr) || $past(wr_nc_addr)) &&
			($stable(nc_saved) || $past(wr_nc_saved)))
		else $error("critical interrupt touched noncritical pair");

	cr_save_a: assert property (@(posedge clk) disable iff (rst) // RULE9
		take_cr |=> cr_saved == $past(msr_in) &&
			cr_ret_addr == $past(save_addr))
		else $error("critical pair not saved");

	wd_next_a: assert property (@(posedge clk) disable iff (rst) // RULE8
		exc.take && exc.kind == IK_WATCHDOG |=>
			cr_ret_addr[31:2] == $past(exc.next_addr[31:2]))
		else $error("watchdog did not save next address");

	rfi_ret_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		rfi && !rfci |=> redirect_valid &&
			redirect_addr == $past(nc_ret_addr) &&
			msr_restore == $past(nc_saved))
		else $error("noncritical return wrong");

	rfci_ret_a: assert property (@(posedge clk) disable iff (rst) // RULE10
		rfci |=> redirect_valid && redirect_addr == $past(cr_ret_addr)
			&& msr_restore == $past(cr_saved))
		else $error("critical return wrong");

	vec_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE13
		exc.take |=> vector_valid && vector_addr[15:0] ==
			$past(exc.offset) && vector_addr[31:16] ==
			$past(prefix[31:16]))
		else $error("handler address wrong");

	mchk_only_a: assert property (@(posedge clk) disable iff (rst) // RULE22
		syn_upd && mchk_en && exc.cause.instr_mchk |=>
			syndrome == 32'h8000_0000)
		else $error("machine check did not clear other bits");

	mchk_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE21
		syn_upd && !mchk_en && syndrome[POS_INSTR_MCHK] |=>
			syndrome[POS_INSTR_MCHK])
		else $error("machine check record lost");

	unsup_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE19
		(syndrome & SYN_UNSUP_MASK) == 32'h0000_0000)
		else $error("unsupported syndrome bit set");

	illegal_one_a: assert property (@(posedge clk) disable iff (rst) // RULE20
		syn_upd && exc.cause == 8'h80 |=>
			syndrome == {$past(!mchk_en && syndrome[POS_INSTR_MCHK]),
				     31'h0800_0000})
		else $error("illegal instruction syndrome wrong");

	prefix_rd_a: assert property (@(posedge clk) disable iff (rst) // RULE14
		special_purpose_register.rd && special_purpose_register.num == SPR_PREFIX |=>
			spr_rdata == $past(prefix) && spr_rdata[15:0] == 16'h0)
		else $error("prefix read wrong");

	cr_read_a: assert property (@(posedge clk) disable iff (rst) // RULE12
		special_purpose_register.rd && special_purpose_register.num == SPR_CR_RET_ADDR |=>
			spr_rdata == $past(cr_ret_addr))
		else $error("critical return address read wrong");

	spr_ack_a: assert property (@(posedge clk) disable iff (rst) // RULE11
		special_purpose_register.rd || special_purpose_register.wr |=> spr_ack)
		else $error("special register access not acknowledged");

	store_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE16
		syn_upd && exc.cause.store && !(mchk_en &&
			exc.cause.instr_mchk) |=> syndrome[POS_STORE])
		else $error("store syndrome flag not set");

	zone_fetch_a: assert property (@(posedge clk) disable iff (rst) // RULE17
		syn_upd && exc.cause.fetch_noexec |=> !syndrome[POS_ZONE])
		else $error("zone flag set on non-executable fetch");

	user_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE18
		syn_upd && exc.cause.user_attr && !(mchk_en &&
			exc.cause.instr_mchk) |=> syndrome[POS_USER_ATTR])
		else $error("user attribute syndrome flag not set");
endmodule

// >>> testbench/test_iss_core.sv
// Self-checking bench for the interrupt state save unit
`timescale 1ns/1ps
module test_iss_core;
	import iss_pkg::*;
	logic        clk, rst, rfi, rfci, spr_ack, vector_valid, redirect_valid;
	logic [31:0] msr_in, spr_rdata, vector_addr, redirect_addr, msr_restore;
	iss_exc_t    exc;
	iss_spr_t    special_purpose_register;
	logic [31:0] m [6];
	logic [32:0] q_spr [$];
	logic [31:0] q_vec [$];
	logic [63:0] q_ret [$];
	logic [32:0] ts;
	logic [63:0] tr;
	int          fail_count, n_checks;
	localparam logic [9:0] NUMS [6] = '{SPR_NC_RET_ADDR, SPR_NC_SAVED,
		SPR_SYNDROME, SPR_PREFIX, SPR_CR_RET_ADDR, SPR_CR_SAVED};
	localparam iss_kind_t KINDS [6] = '{IK_NONCRIT, IK_SYSCALL,
		IK_CRIT_INPUT, IK_MCHECK, IK_WATCHDOG, IK_DEBUG};

	iss_core i_dut (
		.clk            (clk),
		.rst            (rst),
		.exc            (exc),
		.msr_in         (msr_in),
		.rfi            (rfi),
		.rfci           (rfci),
		.special_purpose_register            (special_purpose_register),
		.spr_rdata      (spr_rdata),
		.spr_ack        (spr_ack),
		.vector_valid   (vector_valid),
		.vector_addr    (vector_addr),
		.redirect_valid (redirect_valid),
		.redirect_addr  (redirect_addr),
		.msr_restore    (msr_restore)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value %s exp %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic int idx(logic [9:0] num);
		foreach (NUMS[i])
			if (NUMS[i] == num)
				return i;
		return 6;
	endfunction

	function automatic logic [31:0] wmask(int i);
		return i == 2 ? SYN_WRITE_MASK : i == 3 ? PREFIX_MASK : 32'hFFFF_FFFF;
	endfunction

	// Unmapped numbers read zero and ignore writes
	task automatic spr_op(logic wr, logic [9:0] num, logic [31:0] wd);
		int i;
		i = idx(num);
		@(negedge clk);
		special_purpose_register <= {~wr, wr, num, wd};
		q_spr.push_back({~wr, (i < 6) ? m[i] : RST_READ});
		if (wr && i < 6)
			m[i] = wd & wmask(i);
		@(negedge clk);
		special_purpose_register <= '0;
	endtask

	// Drives one take in the current cycle and predicts its effects
	task automatic take(iss_kind_t k, logic [31:0] ms, logic [7:0] cz);
		iss_exc_t    e;
		logic [95:0] r;
		logic [31:0] sv, sy;
		logic        en;
		r = {$urandom, $urandom, $urandom};
		e = r[93:0];
		e.take = 1'b1;
		e.kind = k;
		// Directed cause when non-zero
		if (cz != 8'h00) begin
			e.cause = cz;
			e.reports = 1'b1;
		end
		sv = (k == IK_SYSCALL || k == IK_WATCHDOG || e.next_seq) ?
			e.next_addr : e.cur_addr;
		sv[1:0] = WORD_ALIGN_ZERO;
		if (k inside {IK_CRIT_INPUT, IK_MCHECK, IK_WATCHDOG, IK_DEBUG}) begin
			m[4] = sv;
			m[5] = ms;
		end else begin
			m[0] = sv;
			m[1] = ms;
		end
		en = ms[POS_MCHK_EN];
		sy = '0;
		sy[POS_ILLEGAL] = e.cause.illegal;
		sy[POS_PRIVILEGED] = e.cause.privileged;
		sy[POS_TRAP] = e.cause.trap;
		sy[POS_STORE] = e.cause.store;
		sy[POS_ZONE] = e.cause.zone & ~e.cause.fetch_noexec;
		sy[POS_USER_ATTR] = e.cause.user_attr;
		sy[POS_INSTR_MCHK] = e.cause.instr_mchk | (~en & m[2][POS_INSTR_MCHK]);
		if (en && e.cause.instr_mchk)
			sy = 32'h8000_0000;
		if (e.reports)
			m[2] = sy;
		q_vec.push_back({m[3][31:16], e.offset});
		exc <= e;
		msr_in <= ms;
	endtask

	task automatic ret(logic c);
		@(negedge clk);
		rfci <= c;
		rfi <= ~c;
		q_ret.push_back(c ? {m[4], m[5]} : {m[0], m[1]});
		@(negedge clk);
		rfi <= 1'b0;
		rfci <= 1'b0;
	endtask

	// Monitor: compare each result against the oldest note
	always @(posedge clk) begin
		#1;
		if (spr_ack === 1'b1) begin
			if (q_spr.size() == 0)
				check("spr_ack", 32'h1, 32'h0);
			else begin
				ts = q_spr.pop_front();
				if (ts[32])
					check("spr_rdata", spr_rdata, ts[31:0]);
			end
		end
		if (vector_valid === 1'b1) begin
			if (q_vec.size() == 0)
				check("vector_valid", 32'h1, 32'h0);
			else
				check("vector_addr", vector_addr, q_vec.pop_front());
		end
		if (redirect_valid === 1'b1) begin
			if (q_ret.size() == 0)
				check("redirect_valid", 32'h1, 32'h0);
			else begin
				tr = q_ret.pop_front();
				check("redirect_addr", redirect_addr, tr[63:32]);
				check("msr_restore", msr_restore, tr[31:0]);
			end
		end
	end

	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		final_report;
	end

	initial begin
		fail_count = 0;
		n_checks = 0;
		rst = 1'b1;
		exc = '0;
		special_purpose_register = '0;
		rfi = 1'b0;
		rfci = 1'b0;
		msr_in = '0;
		m = '{RST_RET_ADDR, RST_SAVED, RST_SYNDROME, RST_PREFIX,
			RST_RET_ADDR, RST_SAVED};
		void'($urandom(32'hE6853D86));
		repeat (2) @(negedge clk);
		rst = 1'b0;
		foreach (NUMS[i]) spr_op(1'b0, NUMS[i], 32'h0);
		spr_op(1'b1, 10'h3D5, $urandom);
		spr_op(1'b0, 10'h3D5, 32'h0);
		foreach (NUMS[i]) spr_op(1'b1, NUMS[i], $urandom);
		foreach (NUMS[i]) spr_op(1'b0, NUMS[i], 32'h0);
		for (int n = 0; n < 60; n++) begin
			@(negedge clk);
			take(KINDS[$urandom_range(5)], $urandom, 8'h00);
			if (n % 4 == 0) begin
				@(negedge clk);
				take(KINDS[$urandom_range(5)], $urandom, 8'h00);
			end
			@(negedge clk);
			exc <= '0;
			foreach (NUMS[i]) spr_op(1'b0, NUMS[i], 32'h0);
			ret(1'($urandom_range(1)));
			if (n % 5 == 0)
				spr_op(1'b1, NUMS[$urandom_range(5)], $urandom);
		end
		@(negedge clk);
		take(IK_NONCRIT, 32'h0000_0000, 8'h01);
		@(negedge clk);
		take(IK_SYSCALL, 32'h0000_0000, 8'h80);
		@(negedge clk);
		take(IK_MCHECK, 32'h0000_0001 << POS_MCHK_EN, 8'h80);
		@(negedge clk);
		take(IK_MCHECK, 32'h0000_0001 << POS_MCHK_EN, 8'h01);
		// Hardware update beats a same-cycle syndrome write
		@(negedge clk);
		take(IK_NONCRIT, 32'h0000_0000, 8'h40);
		special_purpose_register <= {1'b0, 1'b1, SPR_SYNDROME, 32'hFFFF_FFFF};
		q_spr.push_back({1'b0, RST_READ});
		// Noncritical take leaves a same-cycle critical write alone
		@(negedge clk);
		take(IK_SYSCALL, 32'h0000_0000, 8'h20);
		special_purpose_register <= {1'b0, 1'b1, SPR_CR_SAVED, 32'h5A5A_A5A5};
		q_spr.push_back({1'b0, RST_READ});
		m[5] = 32'h5A5A_A5A5;
		@(negedge clk);
		exc <= '0;
		special_purpose_register <= '0;
		foreach (NUMS[i]) spr_op(1'b0, NUMS[i], 32'h0);
		for (int w = 0; w < 20 && q_spr.size() + q_vec.size() +
			q_ret.size() > 0; w++)
			@(negedge clk);
		if (q_spr.size() + q_vec.size() + q_ret.size() > 0)
			fail_count++;
		final_report;
	end
endmodule
